// *** sbr_consts.vh ***
// Function
// (R1) Prescaler divides bus clock by code plus one
// (R2) Rate divider divides by two to 256
// (R3) Bit rate register readable and writable anytime
// (R4) Status unused bits read zero, writes ignored
// (R5) Transfer done sets receive full flag bit7
// (R6) Receive full clears: status read, data read
// (R7) Transmit empty clears: status read, data write
// (R8) Data write without seen empty flag discarded
// (R9) Transmit empty and enable raise interrupt
// (R10) Idle write moves straight into shifter quickly
// (R11) Transfer end loads queued byte, sets empty
// (R12) Select low in fault mode sets fault flag
// (R13) Fault clears: status read, control write
// (R14) Receive or fault flag with enable interrupts
// (R15) Disable aborts, clears buffers, resets flags; the mode fault flag is kept and keeps its own clear sequence
// (R16) Divider counters held while disabled or idle; the idle hold applies in master mode only
`ifndef SBR_CONSTS_VH
`define SBR_CONSTS_VH
// Word addresses on the register bus (byte address >> 2)
`define SBR_ADDR_CTRL1 3'h0
`define SBR_ADDR_CTRL2 3'h1
`define SBR_ADDR_RATE 3'h2
`define SBR_ADDR_STAT 3'h3
`define SBR_ADDR_DATA 3'h4
`define SBR_ADDR_EVT 3'h5
`define SBR_ADDR_EMASK 3'h6
// Control one fields
`define SBR_C1_RXIE 7
`define SBR_C1_ON 6
`define SBR_C1_TXIE 5
`define SBR_C1_MASTER_SELECT 4
`define SBR_C1_SELECT_OUTPUT_ENABLE 1
// Control two field
`define SBR_C2_FEN 4
`define SBR_C2_MASK 8'h1b
// Status fields
`define SBR_ST_RXF 7
`define SBR_ST_TXE 5
`define SBR_ST_MODE_FAULT_FLAG 4
// Bit rate fields
`define SBR_BR_PRE_LSB 4
`define SBR_BR_MASK 8'h77
// Reset values
`define SBR_C1_RST 8'h04
`define SBR_C2_RST 8'h00
`define SBR_BR_RST 8'h00
// Event status bits: rx full, tx empty, mode fault
`define SBR_EVT_W 3
`endif

// *** sbr_rate_gen.v ***
`timescale 1ns/100ps
`default_nettype none
// Prescaler then power-of-two divider, one-cycle tick per bit half period
module sbr_rate_gen (
  input wire clk,
  input wire resetn,
  input wire hold,
  input wire [2:0] prescale_select,
  input wire [2:0] rate_divisor_select,
  output reg bit_tick
);
  reg [2:0] pre_q; // Prescaler count
  reg [7:0] div_q; // Rate divider count
  wire pre_end;
  wire [7:0] div_last;
  assign pre_end = (pre_q == prescale_select); // Divide by code plus one [R1]
  // Divisor 2^(code+1) minus one, as a terminal count [R2]
  assign div_last = (8'h02 << rate_divisor_select) - 8'h01;
  // Counters restart on hold so each transfer gets a full first period
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pre_q <= 3'h0;
      div_q <= 8'h00;
      bit_tick <= 1'b0;
    end else if (hold) begin
      pre_q <= 3'h0; // [R16]
      div_q <= 8'h00; // [R16]
      bit_tick <= 1'b0;
    end else begin
      bit_tick <= 1'b0;
      if (pre_end) begin
        pre_q <= 3'h0;
        if (div_q >= div_last) begin
          div_q <= 8'h00;
          bit_tick <= 1'b1;
        end else begin
          div_q <= div_q + 8'h01;
        end
      end else begin
        pre_q <= pre_q + 3'h1;
      end
    end
  end
endmodule // sbr_rate_gen
`default_nettype wire

// *** sbr_top.v ***
`timescale 1ns/100ps
`default_nettype none
`include "sbr_consts.vh"
// Bit rate and status flag logic of a byte serial unit, Avalon-MM slave
module sbr_top (
  input wire clk,
  input wire resetn,
  input wire [2:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  input wire select_n,
  input wire shift_done,
  input wire [7:0] shift_rx_byte,
  output reg shift_load,
  output reg [7:0] shift_tx_byte,
  output reg bit_rate_tick,
  output reg rate_hold,
  output reg master_mode,
  output reg irq
);
  // Register bank
  reg [7:0] control_one_q; // Control one
  reg [7:0] control_two_q; // Control two
  reg [7:0] bit_rate_setup_q; // Prescale and rate selects
  reg rx_full_flag_q; // Receive buffer full
  reg tx_empty_flag_q; // Transmit buffer empty
  reg mode_fault_flag_q; // Master mode fault
  reg [7:0] rx_buf_q; // Receive buffer
  reg [7:0] tx_buf_q; // Transmit buffer
  reg tx_full_q; // Transmit buffer holds a byte
  reg busy_q; // Shifter busy with a transfer
  reg rxf_armed_q; // Status read saw rx full
  reg txe_armed_q; // Status read saw tx empty
  reg mode_fault_flag_armed_q; // Status read saw mode fault
  reg sel_q; // Previous select level
  reg [2:0] evt_q; // Sticky event status
  reg [2:0] emask_q; // Event mask
  reg ack_q; // Access answered this cycle
  wire unit_on;
  wire master_select;
  wire fault_function_enable;
  wire select_output_enable;
  wire fault_mode;
  wire req;
  wire rd_stat;
  wire rd_data;
  wire wr_data;
  wire wr_c1;
  wire wr_ok;
  wire tick;
  wire [7:0] status_val;
  wire flag_irq;
  wire [2:0] evt_set;
  assign unit_on = control_one_q[`SBR_C1_ON];
  assign master_select = control_one_q[`SBR_C1_MASTER_SELECT];
  assign select_output_enable = control_one_q[`SBR_C1_SELECT_OUTPUT_ENABLE];
  assign fault_function_enable = control_two_q[`SBR_C2_FEN];
  // Select acts as fault input only in this one setting [R12]
  assign fault_mode = master_select & fault_function_enable & ~select_output_enable;
  // A request is taken on the cycle where waitrequest is low
  assign req = (avs_read | avs_write) & ack_q;
  assign rd_stat = req & avs_read & (avs_address == `SBR_ADDR_STAT);
  assign rd_data = req & avs_read & (avs_address == `SBR_ADDR_DATA);
  assign wr_data = req & avs_write & (avs_address == `SBR_ADDR_DATA);
  assign wr_c1 = req & avs_write & (avs_address == `SBR_ADDR_CTRL1);
  // Data write counts only after a status read saw room [R8]
  assign wr_ok = wr_data & txe_armed_q & tx_empty_flag_q & unit_on;
  // Unused status positions read zero [R4]
  assign status_val = {rx_full_flag_q, 1'b0, tx_empty_flag_q, mode_fault_flag_q, 4'h0};
  // Hardware flag interrupt sources [R9] [R14]
  assign flag_irq = (tx_empty_flag_q & control_one_q[`SBR_C1_TXIE])
    | ((rx_full_flag_q | mode_fault_flag_q) & control_one_q[`SBR_C1_RXIE]);

  // Rate generator, held while off or idle master [R16]
  sbr_rate_gen u_rate (
    .clk(clk),
    .resetn(resetn),
    .hold(rate_hold),
    .prescale_select(bit_rate_setup_q[`SBR_BR_PRE_LSB +: 3]),
    .rate_divisor_select(bit_rate_setup_q[2:0]),
    .bit_tick(tick)
  );

  // Waitrequest: one wait cycle per access, then the answer
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ack_q <= 1'b0;
      avs_waitrequest <= 1'b1;
    end else begin
      ack_q <= (avs_read | avs_write) & ~ack_q;
      avs_waitrequest <= ~((avs_read | avs_write) & ~ack_q);
    end
  end

  // Read data mux, unmapped words read zero
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      avs_readdata <= 32'h0;
    end else if ((avs_read | avs_write) & ~ack_q & avs_read) begin
      case (avs_address)
        `SBR_ADDR_CTRL1: avs_readdata <= {24'h0, control_one_q};
        `SBR_ADDR_CTRL2: avs_readdata <= {24'h0, control_two_q};
        `SBR_ADDR_RATE: avs_readdata <= {24'h0, bit_rate_setup_q}; // [R3]
        `SBR_ADDR_STAT: avs_readdata <= {24'h0, status_val}; // [R4]
        `SBR_ADDR_DATA: avs_readdata <= {24'h0, rx_buf_q};
        `SBR_ADDR_EVT: avs_readdata <= {29'h0, evt_q};
        `SBR_ADDR_EMASK: avs_readdata <= {29'h0, emask_q};
        default: avs_readdata <= 32'h0;
      endcase
    end else begin
      avs_readdata <= 32'h0;
    end
  end

  // Configuration registers, writable at any time [R3]
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      control_one_q <= `SBR_C1_RST;
      control_two_q <= `SBR_C2_RST;
      bit_rate_setup_q <= `SBR_BR_RST;
      emask_q <= 3'h0;
    end else if (req & avs_write) begin
      case (avs_address)
        `SBR_ADDR_CTRL1: control_one_q <= avs_writedata[7:0];
        `SBR_ADDR_CTRL2: control_two_q <= avs_writedata[7:0] & `SBR_C2_MASK;
        `SBR_ADDR_RATE: bit_rate_setup_q <= avs_writedata[7:0] & `SBR_BR_MASK; // [R3]
        `SBR_ADDR_EMASK: emask_q <= avs_writedata[2:0];
        default: emask_q <= emask_q; // Status writes change nothing [R4]
      endcase
    end
  end

  // Clear sequences: arm on status read seeing the flag set
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rxf_armed_q <= 1'b0;
      txe_armed_q <= 1'b0;
      mode_fault_flag_armed_q <= 1'b0;
    end else if (rd_stat) begin
      rxf_armed_q <= rx_full_flag_q; // [R6]
      txe_armed_q <= tx_empty_flag_q; // [R7]
      mode_fault_flag_armed_q <= mode_fault_flag_q; // [R13]
    end else begin
      if (rd_data) rxf_armed_q <= 1'b0;
      if (wr_data) txe_armed_q <= 1'b0;
      if (wr_c1) mode_fault_flag_armed_q <= 1'b0;
    end
  end

  // Buffers, shifter hand-off and flags
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rx_full_flag_q <= 1'b0;
      tx_empty_flag_q <= 1'b1;
      mode_fault_flag_q <= 1'b0;
      rx_buf_q <= 8'h00;
      tx_buf_q <= 8'h00;
      tx_full_q <= 1'b0;
      busy_q <= 1'b0;
      shift_load <= 1'b0;
      shift_tx_byte <= 8'h00;
    end else if (!unit_on) begin
      // Disabled: abort, empty buffers, restart state [R15]
      rx_full_flag_q <= 1'b0;
      tx_empty_flag_q <= 1'b1;
      rx_buf_q <= 8'h00;
      tx_buf_q <= 8'h00;
      tx_full_q <= 1'b0;
      busy_q <= 1'b0;
      shift_load <= 1'b0;
      // Fault flag keeps its own clear sequence even while off
      if (wr_c1 & mode_fault_flag_armed_q) mode_fault_flag_q <= 1'b0;
    end else begin
      shift_load <= 1'b0;
      // Receive side: done sets, set wins over clear [R5] [R6]
      if (shift_done) begin
        // Overrun drops the new byte, as there is no overrun flag
        if (!rx_full_flag_q) rx_buf_q <= shift_rx_byte;
        rx_full_flag_q <= 1'b1; // [R5]
      end else if (rd_data & rxf_armed_q) begin
        rx_full_flag_q <= 1'b0; // [R6]
      end
      // Transmit side
      if (wr_ok) begin
        tx_buf_q <= avs_writedata[7:0];
        tx_full_q <= 1'b1;
        tx_empty_flag_q <= 1'b0; // [R7]
      end else if (tx_full_q & (~busy_q | shift_done)) begin
        // Idle or just finished: byte moves to shifter [R10] [R11]
        shift_tx_byte <= tx_buf_q;
        shift_load <= 1'b1;
        tx_full_q <= 1'b0;
        busy_q <= 1'b1;
        tx_empty_flag_q <= 1'b1; // [R10] [R11]
      end else if (shift_done) begin
        busy_q <= 1'b0; // Nothing queued, flag stays set [R11]
      end
      // Mode fault on falling select, set wins over clear [R12] [R13]
      if (fault_mode & sel_q & ~select_n) begin
        mode_fault_flag_q <= 1'b1; // [R12]
      end else if (wr_c1 & mode_fault_flag_armed_q) begin
        mode_fault_flag_q <= 1'b0; // [R13]
      end
    end
  end

  // Select edge history, tick, rate hold and master mode outputs
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sel_q <= 1'b1;
      bit_rate_tick <= 1'b0;
      rate_hold <= 1'b1;
      master_mode <= 1'b0;
    end else begin
      sel_q <= select_n;
      bit_rate_tick <= tick;
      // Held off, or idle master with nothing to send [R16]
      rate_hold <= ~unit_on | (master_select & ~busy_q & ~tx_full_q);
      master_mode <= master_select;
    end
  end

  // Sticky events: set wins over write-one-to-clear
  assign evt_set = {mode_fault_flag_q, tx_empty_flag_q, rx_full_flag_q};
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      evt_q <= 3'h0;
      irq <= 1'b0;
    end else begin
      if (req & avs_write & (avs_address == `SBR_ADDR_EVT)) begin
        evt_q <= (evt_q & ~avs_writedata[2:0]) | evt_set;
      end else begin
        evt_q <= evt_q | evt_set;
      end
      irq <= flag_irq | (|(evt_q & emask_q)); // [R9] [R14]
    end
  end
endmodule // sbr_top
`default_nettype wire

// *** sbr_peer.sv ***
`timescale 1ns/100ps
`default_nettype none
// Far side: the shifter and its serial peer, answering each load after DLY cycles
module sbr_peer #(parameter int DLY = 40) (
  input wire logic clk,
  input wire logic shift_load,
  input wire logic [7:0] shift_tx_byte,
  input wire logic fault,
  output logic shift_done,
  output logic [7:0] shift_rx_byte,
  output logic select_n
);
  int cnt = 0; // Cycles left in the running transfer
  logic [7:0] tx_q = 8'h00; // Byte now in the shifter
  initial shift_done = 1'b0;
  initial shift_rx_byte = 8'h5a;
  // Idle receive lines toggle, so a stale byte is never mistaken for a fresh one
  always @(posedge clk) begin
    shift_done <= 1'b0;
    shift_rx_byte <= ~shift_rx_byte;
    if (shift_load) begin
      tx_q <= shift_tx_byte;
      cnt <= DLY;
    end else if (cnt == 1) begin
      shift_done <= 1'b1;
      shift_rx_byte <= ~tx_q;
      cnt <= 0;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end
  end
  // A competing master pulls select low on command
  assign select_n = ~fault;
endmodule // sbr_peer
`default_nettype wire

// *** sbr_top_props.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "sbr_consts.vh"
// Watches the bus handshake, status layout and the shifter and tick strobes
module sbr_props (
  input wire clk,
  input wire resetn,
  input wire [2:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  input wire shift_load,
  input wire bit_rate_tick,
  input wire rate_hold,
  input wire master_mode
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // Request waiting, read answered at one place, write taken at control one
  sequence s_req; (avs_read || avs_write) && avs_waitrequest; endsequence
  sequence s_rd(a); avs_read && !avs_waitrequest && avs_address == a; endsequence
  sequence s_c1; avs_write && !avs_waitrequest && avs_address == `SBR_ADDR_CTRL1; endsequence
  property p_answer; s_req |=> !avs_waitrequest; endproperty
  a_answer: assert property (p_answer) else $error("bus answer late");
  property p_stand; !avs_waitrequest |=> avs_waitrequest; endproperty
  a_stand: assert property (p_stand) else $error("answer held too long");
  property p_stat; s_rd(`SBR_ADDR_STAT) |-> (avs_readdata & 32'hffffff4f) == 32'h0; endproperty
  a_stat: assert property (p_stat) else $error("unused status bit set");
  property p_void; s_rd(3'h7) |-> avs_readdata == 32'h0; endproperty
  a_void: assert property (p_void) else $error("unmapped read not zero");
  property p_load; shift_load |=> !shift_load; endproperty
  a_load: assert property (p_load) else $error("load strobe too long");
  property p_tick; bit_rate_tick |=> !bit_rate_tick; endproperty
  a_tick: assert property (p_tick) else $error("tick too long");
  property p_hold; rate_hold [*3] |-> !bit_rate_tick; endproperty
  a_hold: assert property (p_hold) else $error("tick while held");
  property p_mst; s_c1 ##0 avs_writedata[`SBR_C1_MASTER_SELECT] |-> ##[1:2] master_mode; endproperty
  a_mst: assert property (p_mst) else $error("master mode not taken");
endmodule // sbr_props
bind sbr_top sbr_props chk (.clk, .resetn, .avs_address, .avs_read, .avs_write,
  .avs_writedata, .avs_readdata, .avs_waitrequest, .shift_load, .bit_rate_tick,
  .rate_hold, .master_mode);
`default_nettype wire

// *** test_spi_bit_rate_and_status_flags.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "sbr_consts.vh"
// Register-level tests of the rate divider and the three status flags
module test_spi_bit_rate_and_status_flags;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [2:0] avs_address = 3'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic fault = 1'b0; // Asks the peer to pull select low
  wire logic [31:0] avs_readdata;
  wire logic avs_waitrequest, select_n, shift_done, shift_load, bit_rate_tick;
  wire logic rate_hold, master_mode, irq;
  wire logic [7:0] shift_rx_byte, shift_tx_byte;
  int failures = 0;
  int n_tests = 0;
  int n_load = 0; // Shifter loads seen
  int n_done = 0; // Transfers finished
  int cyc = 0;
  int t_tick = 0;
  int per = 0; // Last spacing between ticks
  logic [7:0] last_tx = 8'h00;
  logic [31:0] q;
  sbr_top DUT (.clk, .resetn, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_readdata, .avs_waitrequest, .select_n, .shift_done, .shift_rx_byte,
    .shift_load, .shift_tx_byte, .bit_rate_tick, .rate_hold, .master_mode, .irq);
  sbr_peer #(.DLY(40)) peer (.clk, .shift_load, .shift_tx_byte, .fault, .shift_done,
    .shift_rx_byte, .select_n);
  // 100 MHz bus clock
  initial forever #5 clk = ~clk;
  // Counts loads and transfers, and measures the tick spacing
  always @(posedge clk) begin
    cyc++;
    if (shift_load === 1'b1) begin
      n_load++;
      last_tx = shift_tx_byte;
    end
    if (shift_done === 1'b1) n_done++;
    if (bit_rate_tick === 1'b1) begin
      per = cyc - t_tick;
      t_tick = cyc;
    end
  end
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask
  // One access, held until waitrequest is seen low; one idle edge after it
  task automatic acc(input logic w, input logic [2:0] a, input logic [7:0] d);
    int k;
    k = 0;
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_write <= w;
    avs_read <= !w;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0 && k < 50) begin
      @(posedge clk);
      k++;
    end
    q = avs_readdata;
    if (k == 50) cmp("waitrequest", 32'h0, 32'h1);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input string nm, input logic [2:0] a, input logic [7:0] e);
    acc(1'b0, a, 8'h00);
    cmp(nm, {24'h0, e}, q);
  endtask
  // Lets the registered interrupt settle first
  task automatic irq_is(input logic e);
    repeat (3) @(posedge clk);
    cmp("irq", {31'h0, e}, {31'h0, irq});
  endtask
  task automatic wait_n(input int t);
    for (int k = 0; k < 400 && n_done < t; k++) @(posedge clk);
    repeat (2) @(posedge clk);
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Cuts a hang short
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    close_out();
  end
  initial begin
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    cmp("hold", 32'h1, {31'h0, rate_hold});
    rd("stat", `SBR_ADDR_STAT, 8'h20);
    acc(1'b1, `SBR_ADDR_RATE, 8'hff);
    rd("rate", `SBR_ADDR_RATE, 8'h77);
    acc(1'b1, `SBR_ADDR_STAT, 8'hff);
    rd("stat", `SBR_ADDR_STAT, 8'h20);
    rd("void", 3'h7, 8'h00);
    acc(1'b1, `SBR_ADDR_CTRL1, 8'h50);
    // Two rate settings, each with one full transfer
    for (int i = 0; i < 2; i++) begin
      acc(1'b1, `SBR_ADDR_RATE, i ? 8'h21 : 8'h10);
      rd("stat", `SBR_ADDR_STAT, 8'h20);
      acc(1'b1, `SBR_ADDR_DATA, i ? 8'hc3 : 8'h3c);
      wait_n(i + 1);
      cmp("tx", i ? 8'hc3 : 8'h3c, last_tx);
      cmp("period", i ? 12 : 4, per);
      rd("stat", `SBR_ADDR_STAT, 8'ha0);
      rd("data", `SBR_ADDR_DATA, i ? 8'h3c : 8'hc3);
      rd("stat", `SBR_ADDR_STAT, 8'h20);
    end
    // Second write without a status read is dropped
    acc(1'b1, `SBR_ADDR_DATA, 8'h11);
    acc(1'b1, `SBR_ADDR_DATA, 8'h22);
    wait_n(3);
    repeat (60) @(posedge clk);
    cmp("loads", 32'h3, n_load);
    rd("stat", `SBR_ADDR_STAT, 8'ha0);
    acc(1'b1, `SBR_ADDR_DATA, 8'h33);
    rd("stat", `SBR_ADDR_STAT, 8'ha0);
    acc(1'b1, `SBR_ADDR_DATA, 8'h44);
    rd("stat", `SBR_ADDR_STAT, 8'h80);
    wait_n(5);
    cmp("queued", 8'h44, last_tx);
    acc(1'b1, `SBR_ADDR_CTRL1, 8'h04);
    rd("stat", `SBR_ADDR_STAT, 8'h20);
    acc(1'b1, `SBR_ADDR_CTRL1, 8'h70);
    irq_is(1'b1);
    acc(1'b1, `SBR_ADDR_CTRL1, 8'hd0);
    irq_is(1'b0);
    acc(1'b1, `SBR_ADDR_EMASK, 8'h01);
    irq_is(1'b1);
    acc(1'b1, `SBR_ADDR_EVT, 8'h01);
    rd("events", `SBR_ADDR_EVT, 8'h02);
    irq_is(1'b0);
    // Mode fault: ignored as slave, flagged as master
    acc(1'b1, `SBR_ADDR_CTRL2, 8'h10);
    acc(1'b1, `SBR_ADDR_CTRL1, 8'h40);
    fault <= 1'b1;
    // Let the select edge reach the flag before the status read is latched
    @(posedge clk);
    rd("stat", `SBR_ADDR_STAT, 8'h20);
    fault <= 1'b0;
    acc(1'b1, `SBR_ADDR_CTRL1, 8'hd0);
    fault <= 1'b1;
    @(posedge clk);
    rd("stat", `SBR_ADDR_STAT, 8'h30);
    irq_is(1'b1);
    fault <= 1'b0;
    acc(1'b1, `SBR_ADDR_CTRL1, 8'hd0);
    rd("stat", `SBR_ADDR_STAT, 8'h20);
    close_out();
  end
endmodule // test_spi_bit_rate_and_status_flags
`default_nettype wire
